//--- design/pcl_device_end.sv
`timescale 1ns/1ns
module pcl_device_end
	import pcl_pkg::*;
#(
	parameter int POR_CYCLES = POR_CYC // power-on delay
) (
	// clocks and reset
	input  wire logic       ref_clk,
	input  wire logic       reset,
	// link to the host
	pcl_link_if.device_end  link,
	// start-up options
	input  wire logic       use_user_clock,
	input  wire logic       user_startup_clock,
	// user i/o on the byte pins
	input  wire logic       byte_pins_user_io,
	input  wire logic [7:0] user_data_out,
	input  wire logic       user_data_drive,
	// status to the core
	output logic            user_mode,
	output logic            config_busy,
	output logic            config_error
);
	// ---------------------------------------------
	// state machine
	// ---------------------------------------------
	typedef enum logic [4:0] {
		DS_POR   = 5'b00001, // power-on delay
		DS_RESET = 5'b00010, // held in reset
		DS_LOAD  = 5'b00100, // taking bytes
		DS_INIT  = 5'b01000, // initialisation
		DS_USER  = 5'b10000  // user mode
	} pcl_dev_state_t;

	pcl_dev_state_t    state;       // current phase
	logic [TMR_W-1:0]  tmr;         // phase timer
	logic [TMR_W-1:0]  edges;       // user clock edges seen
	logic              status_seen; // status line seen high
	logic              load_clear;  // holds load side cleared
	logic              load_rst;    // load side async reset

	// ---------------------------------------------
	// pin filters: three flops, second and third agree
	// ---------------------------------------------
	logic [SYNC_W-1:0] s1;   // first stage, read by s2 only
	logic [SYNC_W-1:0] s2;   // second stage
	logic [SYNC_W-1:0] s3;   // third stage
	logic [SYNC_W-1:0] filt; // accepted level
	logic [SYNC_W-1:0] pins; // raw inputs
	logic              req_f;    // request line, filtered
	logic              stat_f;   // status line, filtered
	logic              uclk_f;   // user clock, filtered
	logic              done_f;   // load side finished
	logic              uclk_d;   // user clock last level
	logic              done_ld;  // load side finished flag

	assign pins = {done_ld, user_startup_clock,
		link.config_status_n, link.config_request_n};
	assign req_f  = filt[0];
	assign stat_f = filt[1];
	assign uclk_f = filt[2];
	assign done_f = filt[3];

	// filter all pins in one bank
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			// lines idle high, the done flag idles low
			s1   <= 4'h7;
			s2   <= 4'h7;
			s3   <= 4'h7;
			filt <= 4'h7;
		end else begin
			s1 <= pins;
			s2 <= s1;
			s3 <= s2;
			// a level counts only when stages agree
			for (int i = 0; i < SYNC_W; i++) begin
				if (s2[i] == s3[i])
					filt[i] <= s3[i];
			end
		end
	end

	// ---------------------------------------------
	// sequencing of the configuration cycle
	// ---------------------------------------------
	// one process owns state, timer and edge count
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state       <= DS_POR;
			tmr         <= '0;
			edges       <= '0;
			status_seen <= 1'b0;
			config_error <= 1'b0;
		end else begin
			config_error <= 1'b0;
			case (state)
				DS_POR: begin
					if (tmr >= TMR_W'(POR_CYCLES - 1)) begin
						state <= DS_RESET;
						tmr   <= '0;
					end else begin
						tmr <= tmr + 1'b1;
					end
				end
				DS_RESET: begin
					status_seen <= 1'b0;
					if (tmr < TMR_W'(STATUS_CYC - 1))
						tmr <= tmr + 1'b1;
					else if (req_f) begin
						state <= DS_LOAD;
						tmr   <= '0;
					end
				end
				DS_LOAD: begin
					if (stat_f)
						status_seen <= 1'b1;
					if (status_seen && !stat_f) begin
						state        <= DS_RESET;
						tmr          <= '0;
						config_error <= 1'b1;
					end else if (done_f) begin
						state <= DS_INIT;
						tmr   <= '0;
						edges <= '0;
					end
				end
				DS_INIT: begin
					if (tmr < TMR_W'(TMR_W'(1) << (TMR_W - 1)))
						tmr <= tmr + 1'b1;
					if (use_user_clock) begin
						if (tmr >= TMR_W'(USR_WAIT_CYC)
							&& uclk_f && !uclk_d)
							edges <= edges + 1'b1;
						if (edges >= TMR_W'(USER_CLK_EDGES))
							state <= DS_USER;
					end else if (tmr >= TMR_W'(STARTUP_CYC - 1)) begin
						state <= DS_USER;
					end
				end
				DS_USER: begin
					tmr <= '0;
				end
				default: begin
					state <= DS_RESET;
					tmr   <= '0;
				end
			endcase
			if (state != DS_POR && !req_f) begin
				state <= DS_RESET;
				tmr   <= '0;
			end
		end
	end

	// remember user clock level for edge finding
	always_ff @(posedge ref_clk or posedge reset) begin
		// matches the filter's reset level, no false edge
		if (reset)
			uclk_d <= 1'b1;
		else
			uclk_d <= uclk_f;
	end

	// ---------------------------------------------
	// open-drain status and complete lines
	// ---------------------------------------------
	// status low within filter delay
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			link.dev_status_o    <= 1'b0;
			link.dev_status_oe_n <= 1'b0;
		end else begin
			// pulled low in delay and reset phases
			if ((state == DS_POR || state == DS_RESET)
				|| (state != DS_POR && !req_f)) begin
				link.dev_status_o    <= 1'b0;
				link.dev_status_oe_n <= 1'b0;
			end else begin
				link.dev_status_o    <= 1'b1;
				link.dev_status_oe_n <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			link.dev_complete_o    <= 1'b0;
			link.dev_complete_oe_n <= 1'b0;
		end else begin
			if ((state == DS_INIT || state == DS_USER)
				&& req_f) begin
				link.dev_complete_o    <= 1'b1;
				link.dev_complete_oe_n <= 1'b1;
			end else begin
				link.dev_complete_o    <= 1'b0;
				link.dev_complete_oe_n <= 1'b0;
			end
		end
	end

	// load side cleared unless loading with status seen high
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			load_clear <= 1'b1;
		else
			load_clear <= !(state == DS_LOAD && status_seen);
	end

	// ---------------------------------------------
	// user side outputs and byte pins
	// ---------------------------------------------
	// user mode shown to the core
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			user_mode   <= 1'b0;
			config_busy <= 1'b1;
		end else begin
			user_mode   <= (state == DS_USER) && req_f;
			config_busy <= (state != DS_USER) || !req_f;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			link.dev_data      <= 8'h00;
			link.dev_data_oe_n <= 1'b1;
		end else begin
			link.dev_data <= user_data_out;
			// only driven in user mode when enabled
			link.dev_data_oe_n <= !(state == DS_USER && req_f
				&& byte_pins_user_io && user_data_drive);
		end
	end

	// ---------------------------------------------
	// load clock domain: byte capture
	// ---------------------------------------------
	// the load clock stops outside frames, so the
	// counter is cleared asynchronously from ref side
	assign load_rst = reset | load_clear;

	logic [CNT_W-1:0] byte_cnt;  // bytes taken

	// one byte on each rising edge
	always_ff @(posedge link.load_clock or posedge load_rst) begin
		if (load_rst) begin
			byte_cnt  <= '0;
			done_ld   <= 1'b0;
		end else if (!done_ld) begin
			byte_cnt  <= byte_cnt + 1'b1;
			if (byte_cnt == CNT_W'(CFG_BYTES - 1))
				done_ld <= 1'b1;
		end
	end
endmodule

//--- design/pcl_host_end.sv
`timescale 1ns/1ns
module pcl_host_end
	import pcl_pkg::*;
#(
	parameter int CF2CK_CYCLES = CF2CK_CYC // request high wait
) (
	// clocks and reset
	input  wire logic       ref_clk,
	input  wire logic       reset,
	// link to the device
	pcl_link_if.host_end    link,
	// command and byte stream
	input  wire logic       start,
	input  wire logic       byte_valid,
	input  wire logic [7:0] byte_data,
	output logic            byte_ready,
	// status to the user
	output logic            busy,
	output logic            done,
	output logic            error
);
	// ---------------------------------------------
	// state machine
	// ---------------------------------------------
	typedef enum logic [4:0] {
		HS_IDLE = 5'b00001, // user mode, lines high
		HS_REQ  = 5'b00010, // request held low
		HS_WAIT = 5'b00100, // waiting before first edge
		HS_LOAD = 5'b01000, // clocking bytes
		HS_DONE = 5'b10000  // finished, clock parked
	} pcl_host_state_t;

	pcl_host_state_t  state;     // current phase
	logic [TMR_W-1:0] tmr;       // phase timer
	logic [TMR_W-1:0] st_tmr;    // time since status high
	logic [PH_W-1:0]  ph;        // load clock phase
	logic             have_byte; // byte placed on pins
	logic             take;      // byte accepted this cycle

	// pin filters, second and third stage agree
	logic [1:0] s1;   // first stage, read by s2 only
	logic [1:0] s2;
	logic [1:0] s3;
	logic [1:0] filt;
	logic       stat_f; // status filtered
	logic       cmpl_f; // complete filtered
	assign stat_f = filt[0];
	assign cmpl_f = filt[1];
	assign take = byte_valid && byte_ready && state == HS_LOAD;

	// filter status and complete lines
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			s1   <= '0;
			s2   <= '0;
			s3   <= '0;
			filt <= '0;
		end else begin
			s1 <= {link.config_complete, link.config_status_n};
			s2 <= s1;
			s3 <= s2;
			for (int i = 0; i < 2; i++) begin
				if (s2[i] == s3[i])
					filt[i] <= s3[i];
			end
		end
	end

	// ---------------------------------------------
	// sequencing, request line and timers
	// ---------------------------------------------
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state <= HS_IDLE;
			tmr   <= '0;
			st_tmr <= '0;
			link.config_request_n <= 1'b1;
			error <= 1'b0;
		end else begin
			error <= 1'b0;
			case (state)
				HS_IDLE, HS_DONE: begin
					if (start) begin
						state <= HS_REQ;
						tmr   <= '0;
						link.config_request_n <= 1'b0;
					end
				end
				HS_REQ: begin
					tmr <= tmr + 1'b1;
					if (tmr >= TMR_W'(REQ_LOW_CYC - 1)) begin
						state  <= HS_WAIT;
						tmr    <= '0;
						st_tmr <= '0;
						link.config_request_n <= 1'b1;
					end
				end
				HS_WAIT: begin
					if (tmr < TMR_W'(CF2CK_CYCLES))
						tmr <= tmr + 1'b1;
					// restart count whenever status is low
					if (!stat_f)
						st_tmr <= '0;
					else if (st_tmr < TMR_W'(ST2CK_CYC))
						st_tmr <= st_tmr + 1'b1;
					if (tmr >= TMR_W'(CF2CK_CYCLES - 1) && stat_f
						&& st_tmr >= TMR_W'(ST2CK_CYC - 1))
						state <= HS_LOAD;
				end
				HS_LOAD: begin
					if (!stat_f) begin
						state <= HS_REQ;
						tmr   <= '0;
						error <= 1'b1;
						link.config_request_n <= 1'b0;
					end else if (cmpl_f) begin
						state <= HS_DONE;
					end
				end
				default: begin
					state <= HS_IDLE;
					link.config_request_n <= 1'b1;
				end
			endcase
		end
	end

	// ---------------------------------------------
	// load clock divider and byte pins
	// ---------------------------------------------
	// clock made by dividing ref_clk; it is no
	// second domain on this side
	// rising edge waits for a held byte, so timing follows the feed
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			link.load_clock     <= 1'b0;
			link.host_data      <= 8'h00;
			link.host_data_oe_n <= 1'b1;
			ph        <= '0;
			have_byte <= 1'b0;
		end else if (state == HS_LOAD && stat_f && !cmpl_f) begin
			link.host_data_oe_n <= 1'b0;
			if (!link.load_clock) begin
				if (take) begin
					link.host_data <= byte_data;
					have_byte      <= 1'b1;
				end
				if (ph < PH_W'(LOAD_HALF - 1))
					ph <= ph + 1'b1;
				else if (have_byte) begin
					link.load_clock <= 1'b1;
					ph              <= '0;
				end
			end else begin
				if (ph < PH_W'(LOAD_HALF - 1))
					ph <= ph + 1'b1;
				else begin
					link.load_clock <= 1'b0;
					ph              <= '0;
					have_byte       <= 1'b0;
				end
			end
		end else begin
			link.load_clock     <= 1'b0;
			link.host_data_oe_n <= 1'b1;
			ph        <= '0;
			have_byte <= 1'b0;
		end
	end

	// ask for a byte while clock low and none held
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			byte_ready <= 1'b0;
		else
			byte_ready <= state == HS_LOAD && !link.load_clock
				&& !have_byte && !take;
	end

	// user status flags
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			busy <= !(state == HS_IDLE || state == HS_DONE);
			done <= state == HS_DONE;
		end
	end
endmodule

//--- design/pcl_link_if.sv
`timescale 1ns/1ns
interface pcl_link_if;
	// ---------------------------------------------
	// pins driven by the host
	// ---------------------------------------------
	logic       config_request_n; // reconfiguration request
	logic       load_clock;       // byte load clock
	logic [7:0] host_data;        // host byte value
	logic       host_data_oe_n;   // host drives bytes, low
	// ---------------------------------------------
	// pins driven by the device
	// ---------------------------------------------
	logic [7:0] dev_data;         // user i/o value
	logic       dev_data_oe_n;    // device drives bytes, low
	logic       dev_status_o;     // status drive value
	logic       dev_status_oe_n;  // status pulled low, low
	logic       dev_complete_o;   // complete drive value
	logic       dev_complete_oe_n; // complete pulled low
	// ---------------------------------------------
	// resolved wires, pull-ups where nobody drives
	// ---------------------------------------------
	logic [7:0] data;
	logic       config_status_n;
	logic       config_complete;
	assign data = !host_data_oe_n ? host_data :
		(!dev_data_oe_n ? dev_data : 8'hFF);
	assign config_status_n = dev_status_oe_n | dev_status_o;
	assign config_complete = dev_complete_oe_n | dev_complete_o;

	modport device_end (
		input  config_request_n, load_clock, data,
		input  config_status_n, config_complete,
		output dev_data, dev_data_oe_n,
		output dev_status_o, dev_status_oe_n,
		output dev_complete_o, dev_complete_oe_n
	);
	modport host_end (
		input  config_status_n, config_complete, data,
		output config_request_n, load_clock,
		output host_data, host_data_oe_n
	);
endinterface

//--- design/pcl_pkg.sv
package pcl_pkg;
	// ---------------------------------------------
	// clock and timing figures
	// ---------------------------------------------
	localparam int CLK_PERIOD_NS  = 20;     // ref_clk period
	localparam int REQ_LOW_MIN_NS = 2000;   // request low pulse
	localparam int STATUS_MIN_NS  = 10000;  // status low pulse
	localparam int CF2CK_MIN_NS   = 100000; // request high to edge
	localparam int ST2CK_MIN_NS   = 2000;   // status high to edge
	localparam int STARTUP_MIN_NS = 20000;  // done to user mode
	localparam int LOAD_MAX_NS    = 200;    // longest load period
	localparam int USER_CLK_EDGES = 4436;   // user clock periods
	localparam int LOAD_WAIT_PER  = 4;      // load periods to wait
	// least times round up to whole cycles
	localparam int REQ_LOW_CYC  =
		(REQ_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STATUS_CYC   =
		(STATUS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CF2CK_CYC    =
		(CF2CK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ST2CK_CYC    =
		(ST2CK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STARTUP_CYC  =
		(STARTUP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int USR_WAIT_CYC =
		(LOAD_WAIT_PER * LOAD_MAX_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	// power-on delay default, about 12 ms
	localparam int POR_CYC      = 600000;
	// ---------------------------------------------
	// widths and sizes
	// ---------------------------------------------
	localparam int TMR_W        = 20;   // shared timer width
	localparam int CNT_W        = 16;   // byte counter width
	localparam int CFG_BYTES    = 64;   // bytes in a bitstream
	localparam int LOAD_HALF    = 4;    // host half period, cycles
	localparam int PH_W         = 3;    // host phase counter width
	localparam int SYNC_W       = 4;    // filtered pin count
endpackage

//--- verif/pcl_chk.sv
`timescale 1ns/1ns
module pcl_chk
	import pcl_pkg::*;
#(
	parameter int CF2CK = CF2CK_CYC // request high wait
) (
	// clock and reset
	input wire logic       ref_clk,
	input wire logic       reset,
	// link wires
	input wire logic       config_request_n,
	input wire logic       load_clock,
	input wire logic [7:0] host_data,
	input wire logic       host_data_oe_n,
	input wire logic       config_status_n,
	input wire logic       config_complete
);
	// ---------------------------------------------
	// helper counters
	// ---------------------------------------------
	localparam int T_MAX = 40; // 800 ns in cycles
	int   lo_cnt;              // status low run
	int   hi_cnt;              // request high, status low
	int   rq_cnt;              // request low run
	int   ok_cnt;              // status high run
	int   rh_cnt;              // request high run
	int   nb_cnt;              // load edges since status high
	logic ck_q;                // load clock one cycle back

	// runs saturate so long idle periods never wrap
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			lo_cnt <= 0;
			ok_cnt <= 0;
			hi_cnt <= 0;
		end else begin
			lo_cnt <= config_status_n ? 0 : lo_cnt + (lo_cnt < 99999);
			ok_cnt <= !config_status_n ? 0 : ok_cnt + (ok_cnt < 99999);
			hi_cnt <= (config_status_n || !config_request_n) ? 0 :
				hi_cnt + (hi_cnt < 99999);
		end
	end
	// request runs both ways
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			rq_cnt <= 0;
			rh_cnt <= 0;
		end else begin
			rq_cnt <= config_request_n ? 0 : rq_cnt + (rq_cnt < 99999);
			rh_cnt <= !config_request_n ? 0 : rh_cnt + (rh_cnt < 99999);
		end
	end
	// byte edges, cleared whenever status drops
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ck_q   <= 1'b0;
			nb_cnt <= 0;
		end else begin
			ck_q   <= load_clock;
			if (!config_status_n)
				nb_cnt <= 0;
			else if (load_clock && !ck_q)
				nb_cnt <= nb_cnt + 1;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	// ---------------------------------------------
	// properties
	// ---------------------------------------------
	sequence s_req_fall;
		$fell(config_request_n);
	endsequence
	sequence s_cd_low;
		##[0:T_MAX] !config_complete;
	endsequence
	sequence s_st_low;
		##[0:T_MAX] !config_status_n;
	endsequence
	property p_cd_low;
		s_req_fall |-> s_cd_low;
	endproperty
	a_cd_low: assert property (p_cd_low)
		else $error("complete not low in time");
	property p_st_low;
		s_req_fall |-> s_st_low;
	endproperty
	a_st_low: assert property (p_st_low)
		else $error("status not low in time");
	property p_st_min;
		$rose(config_status_n) |-> lo_cnt >= STATUS_CYC;
	endproperty
	a_st_min: assert property (p_st_min)
		else $error("status low pulse too short");
	// limitation: holds only with a shortened power-on delay
	property p_st_max;
		hi_cnt <= 5000;
	endproperty
	a_st_max: assert property (p_st_max)
		else $error("status held low too long");
	property p_req_min;
		$rose(config_request_n) |-> rq_cnt >= REQ_LOW_CYC;
	endproperty
	a_req_min: assert property (p_req_min)
		else $error("request low pulse too short");
	property p_ck_ord;
		$rose(load_clock) |-> ok_cnt >= ST2CK_CYC && rh_cnt >= CF2CK;
	endproperty
	a_ck_ord: assert property (p_ck_ord)
		else $error("load edge too early");
	property p_data_hold;
		$rose(load_clock) |-> !host_data_oe_n && $stable(host_data);
	endproperty
	a_data_hold: assert property (p_data_hold)
		else $error("byte not set before load edge");
	property p_done_cnt;
		$rose(config_complete) |-> nb_cnt == CFG_BYTES;
	endproperty
	a_done_cnt: assert property (p_done_cnt)
		else $error("complete rose at wrong byte count");
	property p_park;
		config_complete && $past(config_complete, 16) |-> !load_clock;
	endproperty
	a_park: assert property (p_park)
		else $error("load clock not parked");
	property p_release;
		config_complete && $past(config_complete, 16) |-> host_data_oe_n;
	endproperty
	a_release: assert property (p_release)
		else $error("host still drives byte pins");
	c_done: cover property ($rose(config_complete));
endmodule

//--- verif/testbench.sv
`timescale 1ns/1ns
module testbench;
	import pcl_pkg::*;
	// one configuration case and its user mode pins
	typedef struct packed {
		logic       usr;
		logic       io;
		logic       drv;
		logic [7:0] ud;
		logic [7:0] gap;
		logic [7:0] pins;
	} pcl_row_t;
	logic       ref_clk, reset, usr_ck, start, byte_valid;
	logic [7:0] byte_data, user_data_out, mon_base;
	logic       use_user_clock, byte_pins_user_io, user_data_drive;
	logic       byte_ready, busy, done, error;
	logic       user_mode, config_busy, config_error, err_seen;
	int         error_cnt, samples_checked, waited, ucnt, mon_idx, r;
	pcl_row_t   rows [4];

	// clocks: user clock free running, unrelated phase
	always #10 ref_clk = ~ref_clk;
	always begin
		#62 usr_ck = 1'b1;
		#63 usr_ck = 1'b0;
	end
	pcl_link_if link ();
	pcl_device_end #(.POR_CYCLES(50)) u_pcl_device_end (
		.ref_clk(ref_clk), .reset(reset), .link(link),
		.use_user_clock(use_user_clock), .user_startup_clock(usr_ck),
		.byte_pins_user_io(byte_pins_user_io),
		.user_data_out(user_data_out), .user_data_drive(user_data_drive),
		.user_mode(user_mode), .config_busy(config_busy),
		.config_error(config_error));
	pcl_host_end #(.CF2CK_CYCLES(50)) u_pcl_host_end (
		.ref_clk(ref_clk), .reset(reset), .link(link), .start(start),
		.byte_valid(byte_valid), .byte_data(byte_data),
		.byte_ready(byte_ready), .busy(busy), .done(done), .error(error));
	pcl_chk #(.CF2CK(50)) u_pcl_chk (
		.ref_clk(ref_clk), .reset(reset),
		.config_request_n(link.config_request_n),
		.load_clock(link.load_clock), .host_data(link.host_data),
		.host_data_oe_n(link.host_data_oe_n),
		.config_status_n(link.config_status_n),
		.config_complete(link.config_complete));

	// ---------------------------------------------
	// shared tasks
	// ---------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task complete_run;
		$display("checks %0d, mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// sel 0 done, 1 user mode, else complete line
	task wait_until(input int sel, input int lim);
		logic hit;
		hit    = 1'b0;
		waited = 0;
		while (!hit) begin
			@(posedge ref_clk);
			waited++;
			case (sel)
				0:       hit = (done === 1'b1);
				1:       hit = (user_mode === 1'b1);
				default: hit = (link.config_complete === 1'b1);
			endcase
			if (!hit && waited >= lim) begin
				error_cnt++;
				$display("wrong value at %0t: wait ran out", $time);
				complete_run();
			end
		end
	endtask
	// bytes base+i, a paused clock after byte 9 when gap set
	// stream may stall between bytes
	task feed(input logic [7:0] base, input int n, input int gap);
		int i, k;
		for (i = 0; i < n; i++) begin
			byte_valid <= 1'b1;
			byte_data  <= base + i[7:0];
			k = 0;
			do begin
				@(posedge ref_clk);
				k++;
			end while (byte_ready !== 1'b1 && k < 5000);
			if (k >= 5000) begin
				error_cnt++;
				$display("wrong value at %0t: byte wait ran out", $time);
				complete_run();
			end
			if (gap > 0 && i == 9) begin
				byte_valid <= 1'b0;
				repeat (gap) @(posedge ref_clk);
			end
		end
		byte_valid <= 1'b0;
	endtask
	task run_row(input pcl_row_t w, input logic [7:0] base);
		use_user_clock    <= w.usr;
		byte_pins_user_io <= w.io;
		user_data_out     <= w.ud;
		user_data_drive   <= w.drv;
		mon_base = base;
		mon_idx  = 0;
		start <= 1'b1;
		@(posedge ref_clk);
		start <= 1'b0;
		repeat (41) @(posedge ref_clk);
		check(link.config_complete, 8'h00);
		check(link.config_status_n, 8'h00);
		check(user_mode, 8'h00);
		check({busy, done}, 8'h02);
		feed(base, CFG_BYTES, w.gap);
		wait_until(2, 200);
		check(mon_idx[7:0], CFG_BYTES[7:0]);
		ucnt = 0;
		wait_until(1, 40000);
		if (w.usr) begin
			check(ucnt >= USER_CLK_EDGES, 8'h01);
			check(ucnt <= USER_CLK_EDGES + 20, 8'h01);
			// each user clock period spans over six ref cycles
			check(waited >= USER_CLK_EDGES * 6, 8'h01);
		end else
			check(waited >= STARTUP_CYC && waited <= 5000, 8'h01);
		wait_until(0, 50);
		check({link.config_request_n, link.config_status_n,
			link.config_complete, config_busy}, 8'h0E);
		check({busy, done}, 8'h01);
		repeat (4) @(posedge ref_clk);
		check(link.data, w.pins);
		$display("test row %0d done", r);
	endtask

	// every byte seen at a load edge matches the stream
	always @(posedge link.load_clock) begin
		check(link.data, mon_base + mon_idx[7:0]);
		mon_idx++;
	end
	always @(posedge usr_ck) ucnt++;
	always @(posedge ref_clk)
		if (config_error === 1'b1 || error === 1'b1)
			err_seen <= 1'b1;

	initial begin
		ref_clk = 0; usr_ck = 0; reset = 1; start = 0; byte_valid = 0;
		byte_data = 8'h00; use_user_clock = 0; byte_pins_user_io = 0;
		user_data_out = 8'h00; user_data_drive = 0; err_seen = 0;
		error_cnt = 0; samples_checked = 0; ucnt = 0; mon_idx = 0;
		mon_base = 8'h00;
		rows[0] = {1'b0, 1'b1, 1'b1, 8'h5A, 8'h00, 8'h5A};
		rows[1] = {1'b0, 1'b0, 1'b1, 8'hC3, 8'h07, 8'hFF};
		rows[2] = {1'b0, 1'b1, 1'b0, 8'h3C, 8'h1E, 8'hFF};
		rows[3] = {1'b1, 1'b1, 1'b1, 8'hA5, 8'h00, 8'hA5};
		repeat (6) @(posedge ref_clk);
		check({link.config_status_n, link.config_complete,
			user_mode, config_busy}, 8'h01);
		reset <= 1'b0;
		for (r = 0; r < 4; r++)
			run_row(rows[r], 8'h10 * r[7:0]);
		// reset in mid-load, then a clean restart
		start <= 1'b1;
		@(posedge ref_clk);
		start <= 1'b0;
		mon_base = 8'h40;
		mon_idx  = 0;
		feed(8'h40, 12, 0);
		reset <= 1'b1;
		repeat (3) @(posedge ref_clk);
		check({link.config_status_n, link.config_complete,
			user_mode, config_busy}, 8'h01);
		reset <= 1'b0;
		run_row(rows[0], 8'h80);
		check(err_seen, 8'h00);
		$display("reset test done");
		complete_run();
	end
endmodule
